// >>> src/clf_loader.sv
// Function
// - bits 3:0 of the first LED byte enable indicator pins 3..0; bits 7:4 ignored
// - the first LED byte supplies only the indicator pin enables of the hardware setup register; its sleep pin fields load from the flags
// - second LED byte: high nibble to LED1 function, low nibble to LED0 function
// - third LED byte: high nibble to LED3 function, low nibble to LED2 function
// - fourth LED byte goes unchanged into behaviour bits 7:0
// - fifth LED byte goes unchanged into behaviour bits 15:8
// - mode select register keeps its value across soft reset (srst) while protection is set; power-on reset clears it
// - behaviour register keeps its value across soft reset (srst) while protection is set; power-on reset clears it
// - flag bit 31 loads the fifty ohm driver enable
// - flag bit 30 loads the driver slew trim
// - flag bits 29:27 load the squelch trim field of the front end
// - flag bits 26:22 are ignored; bit 21 loads the interchip lane swap
// - flag bit 20 loads suspend allow of usb setup register zero
// - flag bits 19:18 load the sleep pin choice field
// - flag bit 17 loads the sleep pin level bit
// - flag bit 16 loads the automatic duplex bit of the mac control register
`timescale 1ns/1ps
`default_nettype none
`include "clf_map.svh"
module clf_loader #(
    parameter int NV_AW   = 16,
    parameter int NV_BASE = 0
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             por,
    input  wire logic             nv_present,
    output logic                  nv_rd_req,
    output logic [NV_AW-1:0]      nv_addr,
    input  wire logic             nv_rd_valid,
    input  wire logic [7:0]       nv_rd_data,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [31:0]           reg_rdata,
    output logic                  cfg_ready,
    output logic [3:0]            indicator_pin_on,
    output logic                  rst_protect,
    output logic [1:0]            sleep_pin_choice,
    output logic                  sleep_pin_level,
    output logic [15:0]           led_mode,
    output logic [15:0]           led_behaviour,
    output logic                  fifty_ohm_driver_on,
    output logic                  driver_slew_trim,
    output logic                  interchip_lane_swap,
    output logic [2:0]            squelch_trim_field,
    output logic                  suspend_allow,
    output logic                  auto_duplex
);
    if (NV_AW < 4) begin : g_bad
        $error("clf_loader: NV_AW too small");
    end
    ////////////////////////////////////////////////////////////////////////
    // sequencing
    clf_pkg::clf_state_t state_q;
    clf_pkg::clf_state_t state_d;
    logic [1:0]          wait_q;
    logic                pres_m_q;
    logic                pres_s_q;
    logic                from_nv_q;
    logic                fetch_start;
    logic                fetch_done;
    logic                byte_we;
    logic [3:0]          byte_idx;
    logic [7:0]          byte_data;
    logic [7:0]          img_q [`CLF_NV_BYTES];
    logic [31:0]         flags;
    logic                loading;
    logic                any_rst;
    assign any_rst     = srst || por;
    assign loading     = (state_q != clf_pkg::ST_DONE);
    assign fetch_start = (state_q == clf_pkg::ST_WAIT) && (wait_q == `CLF_SYNC_CYC) && pres_s_q;
    assign flags       = {img_q[`CLF_IDX_FLG0 + 3], img_q[`CLF_IDX_FLG0 + 2],
                          img_q[`CLF_IDX_FLG0 + 1], img_q[`CLF_IDX_FLG0]};
    // strap pin, two stages before anything looks at it
    always_ff @(posedge ref_clk) begin
        pres_m_q <= nv_present;
        pres_s_q <= pres_m_q;
    end
    always_comb begin
        state_d = state_q;
        case (state_q)
            clf_pkg::ST_WAIT: begin
                if (wait_q == `CLF_SYNC_CYC)
                    state_d = pres_s_q ? clf_pkg::ST_FETCH : clf_pkg::ST_DONE;
            end
            clf_pkg::ST_FETCH: begin
                if (fetch_done)
                    state_d = clf_pkg::ST_APPLY;
            end
            clf_pkg::ST_APPLY: state_d = clf_pkg::ST_DONE;
            clf_pkg::ST_DONE:  state_d = clf_pkg::ST_DONE;
            default:           state_d = clf_pkg::ST_WAIT;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            state_q   <= clf_pkg::ST_WAIT;
            wait_q    <= 2'h0;
            from_nv_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == clf_pkg::ST_WAIT && wait_q != `CLF_SYNC_CYC)
                wait_q <= wait_q + 2'h1;
            if (state_q == clf_pkg::ST_APPLY)
                from_nv_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (byte_we)
            img_q[byte_idx] <= byte_data;
    end
    clf_nv_fetch #(
        .NV_AW   (NV_AW),
        .NBYTES  (`CLF_NV_BYTES),
        .NV_BASE (NV_BASE)
    ) u_fetch (
        .ref_clk     (ref_clk),
        .srst        (any_rst),
        .start       (fetch_start),
        .nv_rd_req   (nv_rd_req),
        .nv_addr     (nv_addr),
        .nv_rd_valid (nv_rd_valid),
        .nv_rd_data  (nv_rd_data),
        .byte_we     (byte_we),
        .byte_idx    (byte_idx),
        .byte_data   (byte_data),
        .done        (fetch_done)
    );
    ////////////////////////////////////////////////////////////////////////
    // register port
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit
    logic        apply;
    logic        sw_wr;
    logic        wr_hw;
    logic        wr_mode;
    logic        wr_behav;
    logic        wr_hsic;
    logic        wr_afe;
    logic        wr_usb0;
    logic        wr_mac;
    logic [31:0] rd_mux;
    logic [31:0] hw_word;
    logic [31:0] stat_word;
    logic        keep_led;
    assign apply    = (state_q == clf_pkg::ST_APPLY);
    assign sw_wr    = reg_wr && !loading && !any_rst;
    assign wr_hw    = sw_wr && hit(reg_addr, `CLF_HW_OFS);
    assign wr_mode  = sw_wr && hit(reg_addr, `CLF_MODE_OFS);
    assign wr_behav = sw_wr && hit(reg_addr, `CLF_BEHAV_OFS);
    assign wr_hsic  = sw_wr && hit(reg_addr, `CLF_HSIC_OFS);
    assign wr_afe   = sw_wr && hit(reg_addr, `CLF_AFE_OFS);
    assign wr_usb0  = sw_wr && hit(reg_addr, `CLF_USB0_OFS);
    assign wr_mac   = sw_wr && hit(reg_addr, `CLF_MAC_OFS);
    // protected contents are software's choice, so a load must not undo them
    assign keep_led = rst_protect;
    assign hw_word   = {24'h00_0000, sleep_pin_level, sleep_pin_choice, rst_protect,
                        indicator_pin_on};
    assign stat_word = {29'h0000_0000, from_nv_q, pres_s_q, cfg_ready};
    assign rd_mux =
        hit(reg_addr, `CLF_HW_OFS)    ? hw_word :
        hit(reg_addr, `CLF_MODE_OFS)  ? {16'h0000, led_mode} :
        hit(reg_addr, `CLF_BEHAV_OFS) ? {16'h0000, led_behaviour} :
        hit(reg_addr, `CLF_HSIC_OFS)  ? {29'h0000_0000, interchip_lane_swap, driver_slew_trim,
                                         fifty_ohm_driver_on} :
        hit(reg_addr, `CLF_AFE_OFS)   ? {29'h0000_0000, squelch_trim_field} :
        hit(reg_addr, `CLF_USB0_OFS)  ? {31'h0000_0000, suspend_allow} :
        hit(reg_addr, `CLF_MAC_OFS)   ? {31'h0000_0000, auto_duplex} :
        hit(reg_addr, `CLF_STAT_OFS)  ? stat_word : 32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (any_rst)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
    always_ff @(posedge ref_clk) begin
        if (any_rst)
            cfg_ready <= 1'b0;
        else
            cfg_ready <= (state_d == clf_pkg::ST_DONE);
    end
    ////////////////////////////////////////////////////////////////////////
    // loaded registers; store image wins over software only during apply
    always_ff @(posedge ref_clk) begin
        if (por)
            rst_protect <= 1'b0;
        else if (wr_hw)
            rst_protect <= reg_wdata[`CLF_HW_PROT_BIT];
    end
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            indicator_pin_on <= 4'h0;
            sleep_pin_choice <= 2'h0;
            sleep_pin_level  <= 1'b0;
        end else if (apply) begin
            indicator_pin_on <= img_q[`CLF_IDX_LED0][3:0];
            sleep_pin_choice <= flags[`CLF_F_SEL_MSB:`CLF_F_SEL_LSB];
            sleep_pin_level  <= flags[`CLF_F_POL];
        end else if (wr_hw) begin
            indicator_pin_on <= reg_wdata[3:0];
            sleep_pin_choice <= reg_wdata[`CLF_HW_SEL_LSB +: 2];
            sleep_pin_level  <= reg_wdata[`CLF_HW_POL_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (por || (srst && !keep_led))
            led_mode <= `CLF_MODE_RST;
        else if (apply && !keep_led)
            led_mode <= {img_q[`CLF_IDX_LED2], img_q[`CLF_IDX_LED1]};
        else if (wr_mode)
            led_mode <= reg_wdata[15:0];
    end

    always_ff @(posedge ref_clk) begin
        if (por || (srst && !keep_led))
            led_behaviour <= `CLF_BEHAV_RST;
        else if (apply && !keep_led)
            led_behaviour <= {img_q[`CLF_IDX_LED4], img_q[`CLF_IDX_LED3]};
        else if (wr_behav)
            led_behaviour <= reg_wdata[15:0];
    end

    // flag bits 26:22 are never looked at
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            fifty_ohm_driver_on <= 1'b0;
            driver_slew_trim    <= 1'b0;
            interchip_lane_swap <= 1'b0;
            squelch_trim_field  <= 3'h0;
            suspend_allow       <= 1'b0;
            auto_duplex         <= 1'b0;
        end else if (apply) begin
            fifty_ohm_driver_on <= flags[`CLF_F_EN50];
            driver_slew_trim    <= flags[`CLF_F_SLEW];
            interchip_lane_swap <= flags[`CLF_F_SWAP];
            squelch_trim_field  <= flags[`CLF_F_SQU_MSB:`CLF_F_SQU_LSB];
            suspend_allow       <= flags[`CLF_F_SUSP];
            auto_duplex         <= flags[`CLF_F_ADD];
        end else begin
            if (wr_hsic) begin
                fifty_ohm_driver_on <= reg_wdata[0];
                driver_slew_trim    <= reg_wdata[1];
                interchip_lane_swap <= reg_wdata[2];
            end
            if (wr_afe)
                squelch_trim_field <= reg_wdata[2:0];
            if (wr_usb0)
                suspend_allow <= reg_wdata[0];
            if (wr_mac)
                auto_duplex <= reg_wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic applied_q;
    always_ff @(posedge ref_clk) applied_q <= apply && !any_rst;

    a_pin_enable_load: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply |=> indicator_pin_on == $past(img_q[`CLF_IDX_LED0][3:0]))
        else $error("pin enables not loaded from first LED byte");
    a_hw_reserved_zero: assert property (@(posedge ref_clk) disable iff (any_rst)
        reg_rd && hit(reg_addr, `CLF_HW_OFS) |=> reg_rdata[31:8] == 24'h00_0000 &&
        reg_rdata[3:0] == $past(indicator_pin_on))
        else $error("hardware setup readback wrong");
    a_mode_low_load: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply && !keep_led |=> led_mode[7:0] == $past(img_q[`CLF_IDX_LED1]))
        else $error("LED0/LED1 function not loaded");
    a_mode_high_load: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply && !keep_led |=> led_mode[15:8] == $past(img_q[`CLF_IDX_LED2]))
        else $error("LED2/LED3 function not loaded");
    a_behav_low_load: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply && !keep_led |=> led_behaviour[7:0] == $past(img_q[`CLF_IDX_LED3]))
        else $error("behaviour low byte not loaded");
    a_behav_high_load: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply && !keep_led |=> led_behaviour[15:8] == $past(img_q[`CLF_IDX_LED4]))
        else $error("behaviour high byte not loaded");
    a_mode_protect: assert property (@(posedge ref_clk) disable iff (por)
        srst && rst_protect |=> $stable(led_mode))
        else $error("mode select lost across protected reset");
    a_behav_protect: assert property (@(posedge ref_clk) disable iff (por)
        srst && rst_protect ##1 srst |=> $stable(led_behaviour))
        else $error("behaviour lost across protected reset");
    a_hsic_flags: assert property (@(posedge ref_clk) disable iff (any_rst)
        applied_q |-> fifty_ohm_driver_on == flags[31] && driver_slew_trim == flags[30])
        else $error("interchip driver flags wrong");
    a_slew_flag: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply |=> driver_slew_trim == $past(flags[30]))
        else $error("slew trim not loaded");
    a_squelch_flag: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply |=> squelch_trim_field == $past(flags[29:27]))
        else $error("squelch trim not loaded");
    a_swap_flag: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply |=> interchip_lane_swap == $past(flags[21]))
        else $error("lane swap not loaded");
    a_suspend_flag: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply |=> suspend_allow == $past(flags[20]))
        else $error("suspend allow not loaded");
    a_sleep_sel_flag: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply |=> sleep_pin_choice == $past(flags[19:18]))
        else $error("sleep pin choice not loaded");
    a_sleep_pol_flag: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply |=> sleep_pin_level == $past(flags[17]))
        else $error("sleep pin level not loaded");
    a_duplex_flag: assert property (@(posedge ref_clk) disable iff (any_rst)
        apply |=> auto_duplex == $past(flags[16]))
        else $error("auto duplex not loaded");
    a_load_before_use: assert property (@(posedge ref_clk) disable iff (any_rst)
        reg_wr && !cfg_ready && hit(reg_addr, `CLF_MAC_OFS) && state_q != clf_pkg::ST_APPLY
        |=> $stable(auto_duplex))
        else $error("software write taken during load");
    a_absent_done: assert property (@(posedge ref_clk) disable iff (any_rst)
        state_q == clf_pkg::ST_WAIT && wait_q == `CLF_SYNC_CYC && !pres_s_q
        |=> cfg_ready && !nv_rd_req)
        else $error("absent store does not finish");

    c_load_from_store: cover property (@(posedge ref_clk) disable iff (any_rst)
        apply ##1 cfg_ready);
    c_protected_apply: cover property (@(posedge ref_clk) disable iff (any_rst)
        apply && keep_led);
    c_protected_reset: cover property (@(posedge ref_clk) disable iff (por)
        srst && rst_protect);
    c_write_refused: cover property (@(posedge ref_clk) disable iff (any_rst)
        reg_wr && loading);
endmodule : clf_loader
`default_nettype wire

// >>> src/clf_map.svh
`ifndef CLF_MAP_SVH
`define CLF_MAP_SVH
// register byte offsets
`define CLF_HW_OFS      8'h00
`define CLF_MODE_OFS    8'h04
`define CLF_BEHAV_OFS   8'h08
`define CLF_HSIC_OFS    8'h0C
`define CLF_AFE_OFS     8'h10
`define CLF_USB0_OFS    8'h14
`define CLF_MAC_OFS     8'h18
`define CLF_STAT_OFS    8'h1C
// image byte positions in the store
`define CLF_NV_BYTES    9
`define CLF_IDX_LED0    0
`define CLF_IDX_LED1    1
`define CLF_IDX_LED2    2
`define CLF_IDX_LED3    3
`define CLF_IDX_LED4    4
`define CLF_IDX_FLG0    5
// hardware setup register fields
`define CLF_HW_PROT_BIT 4
`define CLF_HW_SEL_LSB  5
`define CLF_HW_POL_BIT  7
// configuration flags word fields
`define CLF_F_EN50      31
`define CLF_F_SLEW      30
`define CLF_F_SQU_MSB   29
`define CLF_F_SQU_LSB   27
`define CLF_F_SWAP      21
`define CLF_F_SUSP      20
`define CLF_F_SEL_MSB   19
`define CLF_F_SEL_LSB   18
`define CLF_F_POL       17
`define CLF_F_ADD       16
// reset values and timing
`define CLF_MODE_RST    16'h0000
`define CLF_BEHAV_RST   16'h0000
`define CLF_SYNC_CYC    2'h2
`endif

// >>> src/clf_pkg.sv
`default_nettype none
package clf_pkg;
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_FETCH = 2'b01,
        ST_APPLY = 2'b11,
        ST_DONE  = 2'b10
    } clf_state_t;
endpackage : clf_pkg
`default_nettype wire

// >>> src/clf_nv_fetch.sv
`timescale 1ns/1ps
`default_nettype none
module clf_nv_fetch #(
    parameter int NV_AW   = 16,
    parameter int NBYTES  = 9,
    parameter int NV_BASE = 0
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             start,
    output logic                  nv_rd_req,
    output logic [NV_AW-1:0]      nv_addr,
    input  wire logic             nv_rd_valid,
    input  wire logic [7:0]       nv_rd_data,
    output logic                  byte_we,
    output logic [3:0]            byte_idx,
    output logic [7:0]            byte_data,
    output logic                  done
);
    if (NBYTES < 1 || NBYTES > 16) begin : g_bad
        $error("clf_nv_fetch: NBYTES out of range");
    end

    logic       busy_q;
    logic [3:0] idx_q;
    logic       last;

    assign last      = (idx_q == 4'(NBYTES - 1));
    assign nv_rd_req = busy_q;
    assign nv_addr   = NV_AW'(NV_BASE) + NV_AW'(idx_q);

    // one read outstanding at a time; the store may take any number of cycles
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            idx_q  <= 4'h0;
        end else if (start && !busy_q) begin
            busy_q <= 1'b1;
            idx_q  <= 4'h0;
        end else if (busy_q && nv_rd_valid) begin
            busy_q <= !last;
            idx_q  <= last ? 4'h0 : idx_q + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            byte_we   <= 1'b0;
            byte_idx  <= 4'h0;
            byte_data <= 8'h00;
            done      <= 1'b0;
        end else begin
            byte_we   <= busy_q && nv_rd_valid;
            byte_idx  <= idx_q;
            byte_data <= nv_rd_data;
            done      <= busy_q && nv_rd_valid && last;
        end
    end
endmodule : clf_nv_fetch
`default_nettype wire

// >>> test/clf_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module clf_store_model (
    input  wire logic        ref_clk,
    input  wire logic        slow,
    input  wire logic [71:0] image,
    input  wire logic        nv_rd_req,
    input  wire logic [15:0] nv_addr,
    output logic             nv_rd_valid,
    output logic [7:0]       nv_rd_data
);
    logic [1:0] wait_q;

    initial begin
        nv_rd_valid = 1'b0;
        nv_rd_data  = 8'h00;
        wait_q      = 2'h0;
    end

    // released data toggles so a late sample never sees the old byte
    always @(posedge ref_clk) begin
        if (nv_rd_valid || !nv_rd_req) begin
            nv_rd_valid <= 1'b0;
            nv_rd_data  <= ~nv_rd_data;
            wait_q      <= 2'h0;
        end else if (slow && wait_q != 2'h3) begin
            wait_q     <= wait_q + 2'h1;
            nv_rd_data <= ~nv_rd_data;
        end else begin
            nv_rd_valid <= 1'b1;
            nv_rd_data  <= image[8*nv_addr[3:0] +: 8];
        end
    end
endmodule : clf_store_model
`default_nettype wire

// >>> test/clf_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "clf_map.svh"
module clf_loader_tb;
    localparam logic [71:0] IMG_A = 72'hA7_EA00_00EF_1296_3CA5;
    logic        ref_clk, srst, por, nv_present, slow, reg_wr, reg_rd;
    logic        nv_rd_req, nv_rd_valid, cfg_ready, rst_protect, sleep_pin_level;
    logic        fifty_ohm_driver_on, driver_slew_trim, interchip_lane_swap;
    logic        suspend_allow, auto_duplex;
    logic [15:0] nv_addr, led_mode, led_behaviour;
    logic [7:0]  nv_rd_data, reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0]  indicator_pin_on;
    logic [1:0]  sleep_pin_choice;
    logic [2:0]  squelch_trim_field;
    logic [71:0] image;
    int          mismatches, num_checks, cycles;

    clf_loader dut (.ref_clk(ref_clk), .srst(srst), .por(por), .nv_present(nv_present),
        .nv_rd_req(nv_rd_req), .nv_addr(nv_addr), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cfg_ready(cfg_ready), .indicator_pin_on(indicator_pin_on),
        .rst_protect(rst_protect), .sleep_pin_choice(sleep_pin_choice), .sleep_pin_level(sleep_pin_level),
        .led_mode(led_mode), .led_behaviour(led_behaviour), .fifty_ohm_driver_on(fifty_ohm_driver_on),
        .driver_slew_trim(driver_slew_trim), .interchip_lane_swap(interchip_lane_swap),
        .squelch_trim_field(squelch_trim_field), .suspend_allow(suspend_allow), .auto_duplex(auto_duplex));

    clf_store_model store (.ref_clk(ref_clk), .slow(slow), .image(image), .nv_rd_req(nv_rd_req),
        .nv_addr(nv_addr), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // limit is several times the longest expected run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic rst(input logic power);
        @(posedge ref_clk);
        srst <= 1'b1;
        por  <= power;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        por  <= 1'b0;
    endtask : rst

    task automatic wait_ready;
        int n;
        n = 0;
        while (cfg_ready !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        #1;
        chk(cfg_ready, 1'b1);
    endtask : wait_ready

    task automatic check_all(input logic [71:0] img, input logic [15:0] mode, input logic [15:0] beh,
                             input logic prot, input logic nv);
        logic [31:0] f;
        f = img[71:40];
        chk(indicator_pin_on, img[3:0]);
        chk(led_mode, mode);
        chk(led_behaviour, beh);
        chk(rst_protect, prot);
        chk(fifty_ohm_driver_on, f[31]);
        chk(driver_slew_trim, f[30]);
        chk(squelch_trim_field, f[29:27]);
        chk(interchip_lane_swap, f[21]);
        chk(suspend_allow, f[20]);
        chk(sleep_pin_choice, f[19:18]);
        chk(sleep_pin_level, f[17]);
        chk(auto_duplex, f[16]);
        rd(`CLF_HW_OFS, {f[17], f[19:18], prot, img[3:0]});
        rd(`CLF_MODE_OFS, mode);
        rd(`CLF_BEHAV_OFS, beh);
        rd(`CLF_HSIC_OFS, {f[21], f[30], f[31]});
        rd(`CLF_AFE_OFS, f[29:27]);
        rd(`CLF_USB0_OFS, f[20]);
        rd(`CLF_MAC_OFS, f[16]);
        rd(`CLF_STAT_OFS, {nv, nv_present, 1'b1});
    endtask : check_all

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst       = 1'b1;
        por        = 1'b1;
        nv_present = 1'b1;
        slow       = 1'b1;
        image      = IMG_A;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0000_0000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        mismatches = 0;
        num_checks = 0;
        cycles     = 0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        por  <= 1'b0;
        #1;
        chk(cfg_ready, 1'b0);
        // early writes must be dropped and the image must win
        wr(`CLF_MODE_OFS, 32'h0000_BEEF);
        wr(`CLF_MAC_OFS, 32'h0000_0001);
        wait_ready();
        check_all(IMG_A, IMG_A[23:8], IMG_A[39:24], 1'b0, 1'b1);
        wr(`CLF_STAT_OFS, 32'hFFFF_FFFF);
        rd(`CLF_STAT_OFS, 32'h0000_0007);
        rd(8'h20, 32'h0000_0000);
        // once loaded, software owns the interchip, front end, usb and mac fields
        wr(`CLF_HSIC_OFS, 32'h0000_0006);
        wr(`CLF_AFE_OFS, 32'h0000_0002);
        wr(`CLF_USB0_OFS, 32'h0000_0001);
        wr(`CLF_MAC_OFS, 32'h0000_0001);
        #1;
        chk({fifty_ohm_driver_on, driver_slew_trim, interchip_lane_swap}, 3'h3);
        chk({squelch_trim_field, suspend_allow, auto_duplex}, 5'h0B);
        // protected registers survive a soft reset and a fresh load
        wr(`CLF_HW_OFS, 32'h0000_0010);
        wr(`CLF_MODE_OFS, 32'h0000_5A5A);
        wr(`CLF_BEHAV_OFS, 32'h0000_C3C3);
        image <= ~IMG_A;
        slow  <= 1'b0;
        rst(1'b0);
        wait_ready();
        check_all(~IMG_A, 16'h5A5A, 16'hC3C3, 1'b1, 1'b1);
        // no store: power-on clears protection and nothing loads
        nv_present <= 1'b0;
        rst(1'b1);
        wait_ready();
        check_all(72'h0, 16'h0000, 16'h0000, 1'b0, 1'b0);
        conclude();
    end
endmodule : clf_loader_tb
`default_nettype wire
